// File: rtl/adc_ctrl_params.svh
`ifndef ADC_CTRL_PARAMS_SVH
`define ADC_CTRL_PARAMS_SVH

// APB register byte addresses
`define ADDR_PIN_SELECT   12'h000
`define ADDR_CONTROL_0    12'h004
`define ADDR_CONTROL_1    12'h008
`define ADDR_RESULT_LOW   12'h00C
`define ADDR_RESULT_HIGH  12'h010
`define ADDR_INT_STATUS   12'h014
`define ADDR_INT_MASK     12'h018
`define ADDR_PORT_CTRL    12'h01C

// Field positions, control 0
`define C0_CHAN0_BIT      0
`define C0_CHAN1_BIT      1
`define C0_POWER_OFF_BIT  6
`define C0_START_BIT      7
`define C0_PENDING_BIT    5
// Field positions, control 1
`define C1_DIV_LSB        0
`define C1_REF_BIT        3
`define C1_CHAN_HIGH_BIT  7
// Interrupt status / mask bits
`define INT_ADC_BIT       0
`define MASK_GLOBAL_BIT   1

// Reset values
`define PIN_SELECT_RST    4'hF
`define CONTROL_0_RST     8'h40
`define CONTROL_1_RST     8'h00
`define PORT_DIR_RST      4'hF

// Timing and result mask
`define CONV_CLK_PERIODS  5'd16
`define DIV_CODE_UNDEF    3'h7
`define RESULT_FULL_SCALE 12'hFFF

`endif

// File: rtl/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_HELD,
      SEQ_CONVERT
   } seq_state_t;

   typedef struct packed {
      logic [2:0] divider;
      logic       ref_ext;
      logic       chan_high;
   } ctrl1_t;

   typedef struct packed {
      logic       start;
      logic       power_off;
      logic [1:0] chan_low;
   } ctrl0_t;

   typedef struct packed {
      logic [3:0] analog_en;
      logic [3:0] dir_eff;
      logic [3:0] pullup_eff;
   } pin_cfg_t;
endpackage : adc_ctrl_pkg

// File: rtl/adc_conversion_control.sv
// Design decisions made here: the APB slave port and the placing of the registers.
`include "adc_ctrl_params.svh"
`timescale 1ns/1ps
`default_nettype none

module adc_conversion_control (
   input  wire logic        mclk,
   input  wire logic        rst_b,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [11:0] sar_data,
   input  wire logic [3:0]  pullup_req,
   output logic      [3:0]  analog_pin_enable,
   output logic      [3:0]  port_a_direction,
   output logic      [3:0]  pullup_enable,
   output logic      [2:0]  analog_channel_sel,
   output logic             ref_source_select,
   output logic             adc_power_off,
   output logic             converter_reset,
   output logic             sample_strobe,
   output logic             adc_irq
);

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [3:0]  pin_sel_r;
   logic [3:0]  port_dir_r;
   adc_ctrl_pkg::ctrl0_t c0_r;
   adc_ctrl_pkg::ctrl1_t c1_r;
   logic [11:0] result_r;
   logic        pending_r;
   logic        int_flag_r;
   logic [1:0]  mask_r;
   logic        start_d_r;
   adc_ctrl_pkg::seq_state_t state_r;
   adc_ctrl_pkg::seq_state_t state_nxt;
   logic [6:0]  div_cnt_r;
   logic [4:0]  per_cnt_r;
   logic [31:0] prdata_r;
   logic        pready_r;
   logic        pslverr_r;
   adc_ctrl_pkg::pin_cfg_t pin_r;
   logic        irq_r;
   logic        strobe_r;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [6:0] div_limit(input logic [2:0] code);
      // Terminal count for /2^code; undefined code treated as /64
      if (code == `DIV_CODE_UNDEF)
         div_limit = 7'h3F;
      else
         div_limit = 7'((7'h01 << code) - 7'h01);
   endfunction : div_limit

   function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
      hit = (a == r);
   endfunction : hit

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   wire access   = psel && penable && !pready_r;
   wire wr       = access && pwrite;
   wire rd       = access && !pwrite;
   wire wr_pin   = wr && hit(paddr, `ADDR_PIN_SELECT);
   wire wr_c0    = wr && hit(paddr, `ADDR_CONTROL_0);
   wire wr_c1    = wr && hit(paddr, `ADDR_CONTROL_1);
   wire wr_ist   = wr && hit(paddr, `ADDR_INT_STATUS);
   wire wr_msk   = wr && hit(paddr, `ADDR_INT_MASK);
   wire wr_dir   = wr && hit(paddr, `ADDR_PORT_CTRL);
   wire mapped   = hit(paddr, `ADDR_PIN_SELECT) ||
                   hit(paddr, `ADDR_CONTROL_0) ||
                   hit(paddr, `ADDR_CONTROL_1) ||
                   hit(paddr, `ADDR_RESULT_LOW) ||
                   hit(paddr, `ADDR_RESULT_HIGH) ||
                   hit(paddr, `ADDR_INT_STATUS) ||
                   hit(paddr, `ADDR_INT_MASK) ||
                   hit(paddr, `ADDR_PORT_CTRL);

   wire [7:0] c0_rd = {c0_r.start, c0_r.power_off, pending_r, 3'h0,
                       c0_r.chan_low};
   wire [7:0] c1_rd = {c1_r.chan_high, 3'h0, c1_r.ref_ext, c1_r.divider};

   wire [31:0] rd_mux =
      hit(paddr, `ADDR_PIN_SELECT)  ? {28'h000_0000, pin_sel_r} :
      hit(paddr, `ADDR_CONTROL_0)   ? {24'h00_0000, c0_rd} :
      hit(paddr, `ADDR_CONTROL_1)   ? {24'h00_0000, c1_rd} :
      hit(paddr, `ADDR_RESULT_LOW)  ? {24'h00_0000, result_r[7:0]} :
      hit(paddr, `ADDR_RESULT_HIGH) ? {28'h000_0000, result_r[11:8]} :
      hit(paddr, `ADDR_INT_STATUS)  ? {31'h0000_0000, int_flag_r} :
      hit(paddr, `ADDR_INT_MASK)    ? {30'h0000_0000, mask_r} :
      hit(paddr, `ADDR_PORT_CTRL)   ? {28'h000_0000, port_dir_r} :
                                      32'h0000_0000;

   // ----------------------------------------------------------------
   // Sequencer decode
   // ----------------------------------------------------------------
   wire [7:0] c0_wdata  = pwdata[7:0];
   wire       start_now = wr_c0 ? c0_wdata[`C0_START_BIT] : c0_r.start;
   wire       power_now = wr_c0 ? c0_wdata[`C0_POWER_OFF_BIT]
                                : c0_r.power_off;
   wire       start_fall = start_d_r && !c0_r.start;
   wire       div_tick  = (div_cnt_r == div_limit(c1_r.divider));
   wire       conv_done = (state_r == adc_ctrl_pkg::SEQ_CONVERT) &&
                          div_tick &&
                          (per_cnt_r == `CONV_CLK_PERIODS - 5'd1);
   // A start rewritten high in the last period discards that conversion
   wire       done_ok   = conv_done && !c0_r.power_off && !c0_r.start;

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         adc_ctrl_pkg::SEQ_IDLE:
            if (!c0_r.power_off && c0_r.start)
               state_nxt = adc_ctrl_pkg::SEQ_HELD;
         adc_ctrl_pkg::SEQ_HELD:
            if (c0_r.power_off)
               state_nxt = adc_ctrl_pkg::SEQ_IDLE;
            else if (start_fall)
               state_nxt = adc_ctrl_pkg::SEQ_CONVERT;
         adc_ctrl_pkg::SEQ_CONVERT:
            if (c0_r.power_off)
               state_nxt = adc_ctrl_pkg::SEQ_IDLE;
            else if (c0_r.start)
               state_nxt = adc_ctrl_pkg::SEQ_HELD;
            else if (conv_done)
               state_nxt = adc_ctrl_pkg::SEQ_IDLE;
      endcase
   end

   // ----------------------------------------------------------------
   // APB slave, one wait state
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end else begin
         pready_r  <= psel && penable && !pready_r;
         pslverr_r <= access && !mapped;
         prdata_r  <= rd ? rd_mux : 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         pin_sel_r  <= `PIN_SELECT_RST;
         port_dir_r <= `PORT_DIR_RST;
         c0_r       <= adc_ctrl_pkg::ctrl0_t'(`CONTROL_0_RST >> 4);
         c1_r       <= adc_ctrl_pkg::ctrl1_t'(5'h00);
         mask_r     <= 2'h0;
      end else begin
         if (wr_pin)
            pin_sel_r <= pwdata[3:0];
         if (wr_dir)
            port_dir_r <= pwdata[3:0];
         if (wr_c0) begin
            c0_r.start     <= c0_wdata[`C0_START_BIT];
            c0_r.power_off <= c0_wdata[`C0_POWER_OFF_BIT];
            c0_r.chan_low  <= {c0_wdata[`C0_CHAN1_BIT],
                               c0_wdata[`C0_CHAN0_BIT]};
         end
         if (wr_c1) begin
            c1_r.divider   <= pwdata[`C1_DIV_LSB +: 3];
            c1_r.ref_ext   <= pwdata[`C1_REF_BIT];
            c1_r.chan_high <= pwdata[`C1_CHAN_HIGH_BIT];
         end
         if (wr_msk)
            mask_r <= pwdata[1:0];
      end
   end

   // ----------------------------------------------------------------
   // Conversion sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         state_r   <= adc_ctrl_pkg::SEQ_IDLE;
         start_d_r <= 1'b0;
         div_cnt_r <= 7'h00;
         per_cnt_r <= 5'h00;
      end else begin
         state_r   <= state_nxt;
         start_d_r <= c0_r.start;
         if (state_r != adc_ctrl_pkg::SEQ_CONVERT || div_tick)
            div_cnt_r <= 7'h00;
         else
            div_cnt_r <= div_cnt_r + 7'h01;
         if (state_r != adc_ctrl_pkg::SEQ_CONVERT)
            per_cnt_r <= 5'h00;
         else if (div_tick)
            per_cnt_r <= per_cnt_r + 5'h01;
      end
   end

   // Pending, result and flag; hardware set wins over software clear
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         pending_r  <= 1'b0;
         result_r   <= 12'h000;
         int_flag_r <= 1'b0;
      end else begin
         if (!c0_r.power_off && c0_r.start)
            pending_r <= 1'b1;
         else if (done_ok)
            pending_r <= 1'b0;
         if (done_ok)
            result_r <= sar_data & `RESULT_FULL_SCALE;
         if (done_ok)
            int_flag_r <= 1'b1;
         else if (wr_ist && pwdata[`INT_ADC_BIT])
            int_flag_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Pin and converter outputs
   // ----------------------------------------------------------------
   wire [3:0] dir_eff = port_dir_r | pin_sel_r;
   wire [3:0] pu_eff  = pullup_req & ~pin_sel_r;
   wire irq_nxt = int_flag_r && mask_r[`INT_ADC_BIT] &&
                  mask_r[`MASK_GLOBAL_BIT];

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         pin_r    <= '{analog_en: `PIN_SELECT_RST, dir_eff: `PORT_DIR_RST,
                       pullup_eff: 4'h0};
         irq_r    <= 1'b0;
         strobe_r <= 1'b0;
      end else begin
         pin_r    <= '{analog_en: pin_sel_r, dir_eff: dir_eff,
                       pullup_eff: pu_eff};
         irq_r    <= irq_nxt;
         strobe_r <= div_tick && (state_r == adc_ctrl_pkg::SEQ_CONVERT);
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         analog_channel_sel <= 3'h0;
         ref_source_select  <= 1'b0;
         adc_power_off      <= 1'b1;
         converter_reset    <= 1'b0;
      end else begin
         analog_channel_sel <= {c1_r.chan_high, c0_r.chan_low};
         ref_source_select  <= c1_r.ref_ext;
         adc_power_off      <= power_now;
         converter_reset    <= start_now && !power_now;
      end
   end

   assign prdata            = prdata_r;
   assign pready            = pready_r;
   assign pslverr           = pslverr_r;
   assign analog_pin_enable = pin_r.analog_en;
   assign port_a_direction  = pin_r.dir_eff;
   assign pullup_enable     = pin_r.pullup_eff;
   assign sample_strobe     = strobe_r;
   assign adc_irq           = irq_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_done_clears_pending: assert property (
      @(posedge mclk) disable iff (!rst_b)
      done_ok |=> !pending_r && int_flag_r)
      else $error("pending or flag wrong after conversion end");
   chk_held_pending: assert property (
      @(posedge mclk) disable iff (!rst_b)
      (c0_r.start && !c0_r.power_off) |=> pending_r)
      else $error("pending not set while start held");
   chk_off_ignores: assert property (
      @(posedge mclk) disable iff (!rst_b)
      c0_r.power_off |=> $stable(result_r))
      else $error("result changed while powered off");
   chk_result_hold: assert property (
      @(posedge mclk) disable iff (!rst_b)
      !done_ok |=> $stable(result_r))
      else $error("result changed without conversion end");
   chk_irq_gating: assert property (
      @(posedge mclk) disable iff (!rst_b)
      adc_irq |-> $past(int_flag_r) && $past(mask_r) == 2'h3)
      else $error("interrupt without both enables");
   chk_pullup_off: assert property (
      @(posedge mclk) disable iff (!rst_b)
      ##1 (pullup_enable & $past(pin_sel_r)) == 4'h0)
      else $error("pull-high on analog pin");
   chk_dir_override: assert property (
      @(posedge mclk) disable iff (!rst_b)
      ##1 (port_a_direction & $past(pin_sel_r)) == $past(pin_sel_r))
      else $error("analog pin not forced to input");
   chk_conv_length: assert property (
      @(posedge mclk) disable iff (!rst_b)
      ($rose(state_r == adc_ctrl_pkg::SEQ_CONVERT) && c1_r.divider == 3'h0
       && !c0_r.start && !c0_r.power_off && !wr_c0) |->
      ##15 conv_done)
      else $error("conversion length not sixteen clocks");
   chk_reset_pins: assert property (
      @(posedge mclk)
      $rose(rst_b) |-> analog_pin_enable == `PIN_SELECT_RST)
      else $error("pins not analog after reset");
   chk_flag_sticky: assert property (
      @(posedge mclk) disable iff (!rst_b)
      int_flag_r && !(wr_ist && pwdata[`INT_ADC_BIT]) |=> int_flag_r)
      else $error("flag lost without software clear");
   chk_pending_source: assert property (
      @(posedge mclk) disable iff (!rst_b)
      $fell(pending_r) |-> $past(done_ok))
      else $error("pending dropped without conversion end");
   chk_strobe_in_conv: assert property (
      @(posedge mclk) disable iff (!rst_b)
      sample_strobe |-> $past(state_r == adc_ctrl_pkg::SEQ_CONVERT))
      else $error("converter clock outside conversion");
   chk_off_idle: assert property (
      @(posedge mclk) disable iff (!rst_b)
      c0_r.power_off |=> state_r == adc_ctrl_pkg::SEQ_IDLE)
      else $error("sequencer active while powered off");

endmodule : adc_conversion_control

`default_nettype wire

// File: dv/adc_conversion_control_tb.sv
`include "adc_ctrl_params.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin \
   miscompares++; $display("[ERR] %s expected %h seen %h", nm, exp, got); \
   end end

module adc_conversion_control_tb;
   logic        mclk = 1'b0;
   logic        rst_b = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [11:0] sar_data = 12'h000;
   logic [3:0]  pullup_req = 4'hF;
   logic [3:0]  analog_pin_enable;
   logic [3:0]  port_a_direction;
   logic [3:0]  pullup_enable;
   logic [2:0]  analog_channel_sel;
   logic        ref_source_select;
   logic        adc_power_off;
   logic        converter_reset;
   logic        sample_strobe;
   logic        adc_irq;
   logic [31:0] rd;
   logic        err;
   int          miscompares = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   int          last_strobe = 0;
   int          gap = 0;
   int          strobes = 0;

   adc_conversion_control adc_conversion_control_i (
      .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sar_data(sar_data),
      .pullup_req(pullup_req), .analog_pin_enable(analog_pin_enable),
      .port_a_direction(port_a_direction), .pullup_enable(pullup_enable),
      .analog_channel_sel(analog_channel_sel),
      .ref_source_select(ref_source_select), .adc_power_off(adc_power_off),
      .converter_reset(converter_reset), .sample_strobe(sample_strobe),
      .adc_irq(adc_irq));

   initial begin
      forever #5 mclk = ~mclk;
   end

   // -------------------------------------------------------------
   // Strobe monitor: pulse count and spacing of the divided clock
   // -------------------------------------------------------------
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (sample_strobe === 1'b1) begin
         strobes <= strobes + 1;
         gap <= cyc - last_strobe;
         last_strobe <= cyc;
      end
   end

   // -------------------------------------------------------------
   // Bus helpers
   // -------------------------------------------------------------
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : end_of_test

   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      // No answer means the bus hung: give up rather than spin
      if (n >= 20) begin
         miscompares++;
         end_of_test();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb

   task automatic settle();
      @(posedge mclk);
      #1;
   endtask : settle

   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   task automatic t_reset();
      apb(0, `ADDR_PIN_SELECT, 0);
      `CHK("pin_sel", 32'h0000_000F, rd)
      apb(0, `ADDR_CONTROL_0, 0);
      `CHK("ctrl0", 32'h0000_0040, rd)
      apb(0, `ADDR_CONTROL_1, 0);
      `CHK("ctrl1", 32'h0000_0000, rd)
      `CHK("pin_en", 4'hF, analog_pin_enable)
      `CHK("pull", 4'h0, pullup_enable)
      `CHK("pwr_off", 1'b1, adc_power_off)
      $display("test reset done");
   endtask : t_reset

   task automatic t_pins();
      apb(1, `ADDR_PORT_CTRL, 0);
      apb(1, `ADDR_PIN_SELECT, 32'h0000_0005);
      settle();
      `CHK("pin_en", 4'h5, analog_pin_enable)
      `CHK("dir", 4'h5, port_a_direction)
      `CHK("pull", 4'hA, pullup_enable)
      apb(1, `ADDR_PIN_SELECT, 0);
      settle();
      `CHK("dir_off", 4'h0, port_a_direction)
      `CHK("pull_off", 4'hF, pullup_enable)
      $display("test pins done");
   endtask : t_pins

   task automatic t_route();
      apb(1, `ADDR_CONTROL_1, 32'h0000_0088);
      apb(1, `ADDR_CONTROL_0, 32'h0000_0003);
      settle();
      `CHK("chan", 3'h7, analog_channel_sel)
      `CHK("ref", 1'b1, ref_source_select)
      `CHK("pwr_on", 1'b0, adc_power_off)
      apb(1, `ADDR_CONTROL_1, 0);
      apb(1, `ADDR_CONTROL_0, 32'h0000_0001);
      settle();
      `CHK("chan1", 3'h1, analog_channel_sel)
      `CHK("ref_sup", 1'b0, ref_source_select)
      $display("test route done");
   endtask : t_route

   task automatic t_held();
      int s0;
      apb(1, `ADDR_CONTROL_0, 32'h0000_0081);
      s0 = strobes;
      repeat (100) @(posedge mclk);
      apb(0, `ADDR_CONTROL_0, 0);
      `CHK("pend_held", 1'b1, rd[`C0_PENDING_BIT])
      `CHK("conv_rst", 1'b1, converter_reset)
      `CHK("no_strobe", s0, strobes)
      // Power-off drops the held start, so the next raise starts from zero
      apb(1, `ADDR_CONTROL_0, 32'h0000_0041);
      `CHK("rst_off", 1'b0, converter_reset)
      $display("test held done");
   endtask : t_held

   task automatic t_convert(input logic [2:0] div);
      logic [11:0] smp;
      int          s0;
      int          n;
      smp = (div == 3'h6) ? 12'hFFF : {div, 9'h1A5};
      sar_data <= smp;
      apb(1, `ADDR_CONTROL_1, {29'h0, div});
      apb(1, `ADDR_CONTROL_0, 32'h0000_0081);
      apb(0, `ADDR_CONTROL_0, 0);
      `CHK("pend_set", 1'b1, rd[`C0_PENDING_BIT])
      s0 = strobes;
      apb(1, `ADDR_CONTROL_0, 32'h0000_0001);
      n = 0;
      do begin
         apb(0, `ADDR_CONTROL_0, 0);
         n++;
      end while (rd[`C0_PENDING_BIT] !== 1'b0 && n < 600);
      `CHK("pend_fall", 1'b0, rd[`C0_PENDING_BIT])
      `CHK("strobes", 16, strobes - s0)
      `CHK("gap", 1 << div, gap)
      apb(0, `ADDR_RESULT_LOW, 0);
      `CHK("res_lo", {24'h0, smp[7:0]}, rd)
      apb(0, `ADDR_RESULT_HIGH, 0);
      `CHK("res_hi", {28'h0, smp[11:8]}, rd)
      apb(0, `ADDR_INT_STATUS, 0);
      `CHK("flag", 1'b1, rd[0])
      `CHK("irq_masked", 1'b0, adc_irq)
      $display("test convert div %0d done", div);
   endtask : t_convert

   task automatic t_irq();
      apb(1, `ADDR_INT_MASK, 32'h0000_0001);
      settle();
      `CHK("irq_noglob", 1'b0, adc_irq)
      apb(1, `ADDR_INT_MASK, 32'h0000_0002);
      settle();
      `CHK("irq_noadc", 1'b0, adc_irq)
      apb(1, `ADDR_INT_MASK, 32'h0000_0003);
      settle();
      `CHK("irq_on", 1'b1, adc_irq)
      apb(1, `ADDR_INT_STATUS, 0);
      settle();
      `CHK("irq_kept", 1'b1, adc_irq)
      apb(1, `ADDR_INT_STATUS, 32'h0000_0001);
      settle();
      `CHK("irq_clr", 1'b0, adc_irq)
      apb(0, `ADDR_INT_STATUS, 0);
      `CHK("flag_clr", 1'b0, rd[0])
      $display("test irq done");
   endtask : t_irq

   task automatic t_power_off();
      int s0;
      sar_data <= 12'h123;
      apb(1, `ADDR_CONTROL_0, 32'h0000_0040);
      s0 = strobes;
      apb(1, `ADDR_CONTROL_0, 32'h0000_00C0);
      apb(1, `ADDR_CONTROL_0, 32'h0000_0040);
      repeat (100) @(posedge mclk);
      `CHK("off_strobe", s0, strobes)
      `CHK("off_pin", 1'b1, adc_power_off)
      apb(0, `ADDR_CONTROL_0, 0);
      `CHK("off_pend", 1'b0, rd[`C0_PENDING_BIT])
      apb(0, `ADDR_RESULT_LOW, 0);
      `CHK("off_res", 32'h0000_00FF, rd)
      $display("test power_off done");
   endtask : t_power_off

   task automatic t_unmapped();
      apb(1, 12'h100, 32'h0000_FFFF);
      `CHK("wr_err", 1'b1, err)
      apb(0, 12'h100, 0);
      `CHK("rd_err", 1'b1, err)
      `CHK("rd_zero", 32'h0000_0000, rd)
      $display("test unmapped done");
   endtask : t_unmapped

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      repeat (10) @(posedge mclk);
      rst_b <= 1'b1;
      t_reset();
      t_pins();
      t_route();
      t_held();
      for (int d = 0; d < 7; d++) begin
         t_convert(d[2:0]);
      end
      t_irq();
      t_power_off();
      t_unmapped();
      end_of_test();
   end
endmodule : adc_conversion_control_tb

`default_nettype wire
